/* hdl/bcpr_pkg.sv */
// constants and state type for the buck control register bank
// assumes one clock domain; register access is decoded inside the bank
package bcpr_pkg;
	localparam int ADDR_W = 10;
	localparam logic [9:0] OFS_BUCKA_CONTROL = 10'h05D;
	localparam logic [9:0] OFS_BUCKB_CONTROL = 10'h05E;
	localparam logic [9:0] OFS_PAGE_CONTROL = 10'h080;
	localparam logic [9:0] OFS_BUCK_CURRENT_LIMIT = 10'h0D0;
	localparam logic [9:0] LOCK_FIRST = 10'h0D0;
	localparam logic [9:0] LOCK_LAST = 10'h14F;
	localparam logic [9:0] BASE_080 = 10'h080;
	localparam logic [9:0] BASE_100 = 10'h100;
	localparam logic [9:0] BASE_200 = 10'h200;
	localparam logic [7:0] RST_BUCKA_CONTROL = 8'h00;
	localparam logic [7:0] RST_BUCKB_CONTROL = 8'h00;
	localparam logic [7:0] RST_PAGE_CONTROL = 8'h00;
	localparam logic [7:0] RST_BUCK_CURRENT_LIMIT = 8'h00;
	localparam int BIT_ON = 0;
	localparam int BIT_ENSRC_LO = 1;
	localparam int BIT_PD_OFF = 3;
	localparam int BIT_VCHOICE = 4;
	localparam int BIT_VSRC_LO = 5;
	localparam int BIT_AUTO_RETURN = 7;
	localparam int BIT_WRITE_REPEAT = 6;
	localparam int ILIM_B_LO = 4;
	localparam logic [12:0] ILIM_BASE_MA = 13'h0FA0;
	localparam logic [12:0] ILIM_STEP_MA = 13'h00C8;
	localparam int N_INPUTS = 5;
	localparam int WARM_CYCLES = 3;

	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] prev;
		logic [2:0] warm;
		logic [7:0] bucka;
		logic [7:0] buckb;
		logic [7:0] page;
		logic [7:0] ilim;
		logic [12:0] ilim_ma;
		logic [7:0] rdata;
		logic ack;
	} bcpr_state_t;
endpackage

/* hdl/bcpr_regs.sv */
// buck control register bank: buck control, page control, current limit
// assumes a same-clock access port from the serial front end and raw control pins
// Summary of operation
// [RULE1] buck A voltage input: none, 1, 2, 4
// [RULE2] buck B voltage input, same encoding and behaviour
// [RULE3] assertion judged by each input's polarity bit
// [RULE4] bit 4 picks voltage setting A or B
// [RULE5] bit 3 set keeps pull-down off
// [RULE6] buck A enable input: none, 0, 1, 3
// [RULE7] buck B enable input, same encoding; bit 0 enables
// [RULE8] auto return clears page after access ends
// [RULE9] bit 6 picks page or repeated write
// [RULE10] I2C page windows 00x, 01x, 10x
// [RULE11] SPI page windows of 128 registers
// [RULE12] buck B limit 4000 mA plus 200 mA steps
// [RULE13] polarity 0 active low, 1 active high
// [RULE14] lock refuses writes to 0xD0 through 0x14F
// [RULE15] reserved page codes select nothing
`timescale 1ns/1ns
`default_nettype none
module bcpr_regs
	import bcpr_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic ACC_SPI,
	input wire logic [7:0] ACC_ADDR,
	input wire logic ACC_WR,
	input wire logic ACC_RD,
	input wire logic [7:0] ACC_WDATA,
	input wire logic ACC_END,
	output logic [7:0] ACC_RDATA,
	output logic ACC_ACK,
	input wire logic [4:0] CONTROL_IN,
	input wire logic [4:0] INPUT_POLARITY,
	input wire logic WRITE_LOCK,
	output logic BUCKA_ON,
	output logic BUCKB_ON,
	output logic BUCKA_USE_SETTING_B,
	output logic BUCKB_USE_SETTING_B,
	output logic BUCKA_PULLDOWN,
	output logic BUCKB_PULLDOWN,
	output logic [12:0] BUCKB_PHASE_LIMIT_MA,
	output logic WRITE_REPEAT
);
	bcpr_state_t r;
	bcpr_state_t next_r;
	logic [9:0] full_addr;
	logic addr_ok;
	logic locked_hit;
	logic [4:0] act;
	logic [4:0] rise;
	logic [4:0] fall;

	function automatic logic [2:0] vsrc_index(input logic [1:0] code);
		case (code)
			2'b01: vsrc_index = 3'd1;
			2'b10: vsrc_index = 3'd2;
			default: vsrc_index = 3'd4;
		endcase
	endfunction

	function automatic logic [2:0] ensrc_index(input logic [1:0] code);
		case (code)
			2'b01: ensrc_index = 3'd0;
			2'b10: ensrc_index = 3'd1;
			default: ensrc_index = 3'd3;
		endcase
	endfunction

	// page window decode
	always_comb
	begin
		full_addr = 10'h000;
		addr_ok = 1'b0;
		if (ACC_SPI)
		begin
			case (r.page[2:0]) // [RULE11]
				3'b000:
				begin
					full_addr = {3'b000, ACC_ADDR[6:0]};
					addr_ok = 1'b1;
				end
				3'b001:
				begin
					full_addr = BASE_080 | {3'b000, ACC_ADDR[6:0]};
					addr_ok = 1'b1;
				end
				3'b010:
				begin
					full_addr = BASE_100 | {3'b000, ACC_ADDR[6:0]};
					addr_ok = 1'b1;
				end
				3'b100:
				begin
					full_addr = BASE_200 | {3'b000, ACC_ADDR[6:0]};
					addr_ok = 1'b1;
				end
				default:
				begin
					full_addr = 10'h000; // [RULE15]
					addr_ok = 1'b0;
				end
			endcase
		end
		else
		begin
			case (r.page[2:1]) // [RULE10]
				2'b00:
				begin
					full_addr = {2'b00, ACC_ADDR};
					addr_ok = 1'b1;
				end
				2'b01:
				begin
					full_addr = BASE_100 | {3'b000, ACC_ADDR[6:0]};
					addr_ok = !ACC_ADDR[7];
				end
				2'b10:
				begin
					full_addr = BASE_200 | {3'b000, ACC_ADDR[6:0]};
					addr_ok = !ACC_ADDR[7];
				end
				default:
				begin
					full_addr = 10'h000; // [RULE15]
					addr_ok = 1'b0;
				end
			endcase
		end
		locked_hit = WRITE_LOCK && full_addr >= LOCK_FIRST && full_addr <= LOCK_LAST; // [RULE14]
	end

	always_comb
	begin
		next_r = r;
		next_r.sync1 = CONTROL_IN;
		next_r.sync2 = r.sync1;
		next_r.warm = {r.warm[1:0], 1'b1};
		act = ~(r.sync2 ^ INPUT_POLARITY); // [RULE3] [RULE13]
		next_r.prev = act;
		// edges ignored until the synchroniser holds real pin values
		rise = r.warm[WARM_CYCLES - 1] ? (act & ~r.prev) : 5'h00;
		fall = r.warm[WARM_CYCLES - 1] ? (~act & r.prev) : 5'h00;
		next_r.ack = ACC_WR | ACC_RD;
		if (ACC_WR && addr_ok && !locked_hit) // [RULE14]
		begin
			case (full_addr)
				OFS_BUCKA_CONTROL: next_r.bucka = ACC_WDATA;
				OFS_BUCKB_CONTROL: next_r.buckb = ACC_WDATA;
				OFS_PAGE_CONTROL: next_r.page = ACC_WDATA;
				OFS_BUCK_CURRENT_LIMIT: next_r.ilim = ACC_WDATA;
				default: next_r.ilim = next_r.ilim;
			endcase
		end
		if (ACC_RD)
		begin
			if (!addr_ok)
				next_r.rdata = 8'h00;
			else
			begin
				case (full_addr)
					OFS_BUCKA_CONTROL: next_r.rdata = r.bucka;
					OFS_BUCKB_CONTROL: next_r.rdata = r.buckb;
					OFS_PAGE_CONTROL: next_r.rdata = r.page;
					OFS_BUCK_CURRENT_LIMIT: next_r.rdata = r.ilim;
					default: next_r.rdata = 8'h00;
				endcase
			end
		end
		// pin transitions win over a host write in the same cycle
		if (r.bucka[6:5] != 2'b00) // [RULE1]
		begin
			if (rise[vsrc_index(r.bucka[6:5])])
				next_r.bucka[BIT_VCHOICE] = 1'b1;
			else if (fall[vsrc_index(r.bucka[6:5])])
				next_r.bucka[BIT_VCHOICE] = 1'b0;
		end
		if (r.buckb[6:5] != 2'b00) // [RULE2]
		begin
			if (rise[vsrc_index(r.buckb[6:5])])
				next_r.buckb[BIT_VCHOICE] = 1'b1;
			else if (fall[vsrc_index(r.buckb[6:5])])
				next_r.buckb[BIT_VCHOICE] = 1'b0;
		end
		if (r.bucka[2:1] != 2'b00) // [RULE6]
		begin
			if (rise[ensrc_index(r.bucka[2:1])])
				next_r.bucka[BIT_ON] = 1'b1;
			else if (fall[ensrc_index(r.bucka[2:1])])
				next_r.bucka[BIT_ON] = 1'b0;
		end
		if (r.buckb[2:1] != 2'b00) // [RULE7]
		begin
			if (rise[ensrc_index(r.buckb[2:1])])
				next_r.buckb[BIT_ON] = 1'b1;
			else if (fall[ensrc_index(r.buckb[2:1])])
				next_r.buckb[BIT_ON] = 1'b0;
		end
		if (ACC_END && r.page[BIT_AUTO_RETURN]) // [RULE8]
			next_r.page[2:0] = 3'b000;
		next_r.ilim_ma = ILIM_BASE_MA + 13'(ILIM_STEP_MA * 13'(next_r.ilim[7:4])); // [RULE12]
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			r <= '0;
			r.bucka <= RST_BUCKA_CONTROL;
			r.buckb <= RST_BUCKB_CONTROL;
			r.page <= RST_PAGE_CONTROL;
			r.ilim <= RST_BUCK_CURRENT_LIMIT;
			r.ilim_ma <= ILIM_BASE_MA;
		end
		else
			r <= next_r;
	end

	assign ACC_RDATA = r.rdata;
	assign ACC_ACK = r.ack;
	assign BUCKA_ON = r.bucka[BIT_ON];
	assign BUCKB_ON = r.buckb[BIT_ON];
	assign BUCKA_USE_SETTING_B = r.bucka[BIT_VCHOICE]; // [RULE4]
	assign BUCKB_USE_SETTING_B = r.buckb[BIT_VCHOICE]; // [RULE4]
	assign BUCKA_PULLDOWN = !r.bucka[BIT_ON] && !r.bucka[BIT_PD_OFF]; // [RULE5]
	assign BUCKB_PULLDOWN = !r.buckb[BIT_ON] && !r.buckb[BIT_PD_OFF]; // [RULE5]
	assign BUCKB_PHASE_LIMIT_MA = r.ilim_ma;
	assign WRITE_REPEAT = r.page[BIT_WRITE_REPEAT]; // [RULE9]

	sequence s_ena_rise;
		r.bucka[2:1] == 2'b01 && rise[0];
	endsequence
	sequence s_enb_fall;
		r.buckb[2:1] == 2'b11 && fall[3] && !rise[3];
	endsequence

	chk_enable_a_rise: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE6]
		s_ena_rise |=> BUCKA_ON)
		else $error("buck A not enabled by its input");
	chk_enable_b_fall: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE7]
		s_enb_fall |=> !BUCKB_ON)
		else $error("buck B not disabled by its input");
	chk_volt_a_pin: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE1]
		(r.bucka[6:5] == 2'b11 && rise[4]) |=> BUCKA_USE_SETTING_B)
		else $error("buck A voltage choice missed input 4");
	chk_volt_b_pin: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE2]
		(r.buckb[6:5] == 2'b10 && fall[2]) |=> !BUCKB_USE_SETTING_B)
		else $error("buck B voltage choice missed input 2");
	chk_polarity_high: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE13]
		(INPUT_POLARITY[1] && r.sync2[1]) |-> act[1])
		else $error("active high input not asserted");
	chk_page_page_auto_return: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE8]
		(ACC_END && r.page[BIT_AUTO_RETURN]) |=> r.page[2:0] == 3'b000)
		else $error("page not returned after access");
	chk_lock_refuse: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE14]
		(ACC_WR && addr_ok && full_addr == OFS_BUCK_CURRENT_LIMIT && WRITE_LOCK)
		|=> $stable(r.ilim))
		else $error("locked limit register was written");
	chk_limit_value: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE12]
		BUCKB_PHASE_LIMIT_MA == 13'(13'd4000 + 13'd200 * 13'(r.ilim[7:4])))
		else $error("phase limit value wrong");
	chk_spi_window: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE11]
		(ACC_SPI && r.page[2:0] == 3'b001) |-> (addr_ok && full_addr[9:7] == 3'b001))
		else $error("spi page one window wrong");
	chk_i2c_reserved: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE10]
		(!ACC_SPI && r.page[2:1] == 2'b11) |-> !addr_ok)
		else $error("reserved i2c page decoded");
	chk_pulldown_off: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RULE5]
		$rose(BUCKA_PULLDOWN) |-> !BUCKA_ON && !r.bucka[BIT_PD_OFF])
		else $error("pull-down on while disabled by bit");
endmodule
`default_nettype wire

/* verif/bcpr_host.sv */
// host model of the register access port
// assumes the bank's clock, one byte per request
`timescale 1ns/1ns
`default_nettype none
module bcpr_host
(
	input wire logic REF_CLK,
	input wire logic ACC_ACK,
	input wire logic [7:0] ACC_RDATA,
	output logic ACC_WR,
	output logic ACC_RD,
	output logic ACC_END,
	output logic [7:0] ACC_ADDR,
	output logic [7:0] ACC_WDATA
);
	initial
	begin
		ACC_WR = 1'b0;
		ACC_RD = 1'b0;
		ACC_END = 1'b0;
		ACC_ADDR = 8'h00;
		ACC_WDATA = 8'h00;
	end
	// request for one cycle, ack and data taken a cycle later
	task acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		@(posedge REF_CLK);
		#1;
		ACC_WR = wr;
		ACC_RD = ~wr;
		ACC_ADDR = a;
		ACC_WDATA = d;
		@(posedge REF_CLK);
		#1;
		ACC_WR = 1'b0;
		ACC_RD = 1'b0;
		ACC_ADDR = ~a;
		ACC_WDATA = ~d;
		ok = ACC_ACK;
		q = ACC_RDATA;
	endtask
	// marks the end of a serial transaction
	task fin;
		@(posedge REF_CLK);
		#1;
		ACC_END = 1'b1;
		@(posedge REF_CLK);
		#1;
		ACC_END = 1'b0;
	endtask
endmodule
`default_nettype wire

/* verif/bcpr_regs_tb.sv */
// self-checking bench for the buck control register bank
// assumes bcpr_pkg and bcpr_host are compiled first
`timescale 1ns/1ns
`default_nettype none
module bcpr_regs_tb
	import bcpr_pkg::*;
;
	logic ref_clk, sys_rst, acc_spi, write_lock, pol;
	logic [4:0] control_in, input_polarity;
	logic [7:0] ilimv;
	logic [7:0] cur [2];
	logic [31:0] seed;
	wire logic acc_wr, acc_rd, acc_end, acc_ack, write_repeat;
	wire logic [7:0] acc_addr, acc_wdata, acc_rdata;
	wire logic [5:0] outs;
	wire logic [12:0] limit_ma;
	int num_errors, n_compared, pin;
	bcpr_regs DUT (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .ACC_SPI(acc_spi),
		.ACC_ADDR(acc_addr), .ACC_WR(acc_wr), .ACC_RD(acc_rd), .ACC_WDATA(acc_wdata),
		.ACC_END(acc_end), .ACC_RDATA(acc_rdata), .ACC_ACK(acc_ack),
		.CONTROL_IN(control_in), .INPUT_POLARITY(input_polarity), .WRITE_LOCK(write_lock),
		.BUCKA_ON(outs[0]), .BUCKB_ON(outs[1]), .BUCKA_PULLDOWN(outs[2]),
		.BUCKB_PULLDOWN(outs[3]), .BUCKA_USE_SETTING_B(outs[4]),
		.BUCKB_USE_SETTING_B(outs[5]), .BUCKB_PHASE_LIMIT_MA(limit_ma),
		.WRITE_REPEAT(write_repeat));
	bcpr_host host (.REF_CLK(ref_clk), .ACC_ACK(acc_ack), .ACC_RDATA(acc_rdata),
		.ACC_WR(acc_wr), .ACC_RD(acc_rd), .ACC_END(acc_end), .ACC_ADDR(acc_addr),
		.ACC_WDATA(acc_wdata));
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [5:0] exp_outs(input logic [7:0] a, input logic [7:0] b);
		return {b[4], a[4], ~b[0] & ~b[3], ~a[0] & ~a[3], b[0], a[0]};
	endfunction
	task chk(input logic [12:0] got, input logic [12:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic ok;
		host.acc(1'b1, a, d, q, ok);
		chk(13'(ok), 13'h1);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic ok;
		host.acc(1'b0, a, 8'h00, q, ok);
		chk(13'({ok, q}), 13'({1'b1, e}));
	endtask
	task settle;
		repeat (5) @(posedge ref_clk);
		#1;
	endtask
	task test_done;
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#1000000;
		num_errors++;
		test_done();
	end
	initial
	begin
		seed = 32'h46B9825B;
		sys_rst = 1'b1;
		acc_spi = 1'b0;
		write_lock = 1'b0;
		control_in = 5'h00;
		input_polarity = 5'h1F;
		num_errors = 0;
		n_compared = 0;
		cur[0] = 8'h00;
		cur[1] = 8'h00;
		repeat (16) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		chk(13'(outs), 13'(exp_outs(8'h00, 8'h00)));
		chk(limit_ma, 13'h0FA0);
		repeat (12)
		begin
			seed = lfsr(seed);
			pin = int'(seed[8]);
			cur[pin] = seed[7:0];
			wr(8'h5D + 8'(pin), cur[pin]);
			chk(13'(outs), 13'(exp_outs(cur[0], cur[1])));
			rd(8'h5D + 8'(pin), cur[pin]);
		end
		for (int k = 0; k < 16; k++)
		begin
			seed = lfsr(seed);
			ilimv = {4'(k), seed[3:0]};
			wr(8'hD0, ilimv);
			chk(limit_ma, 13'(4000 + 200 * k));
		end
		write_lock = 1'b1;
		wr(8'hD0, ~ilimv);
		rd(8'hD0, ilimv);
		write_lock = 1'b0;
		wr(8'h80, 8'h40);
		chk(13'(write_repeat), 13'h1);
		for (int p = 0; p < 8; p++)
		begin
			wr(8'h80, 8'h80 | 8'(p));
			rd(8'h5D, (p < 2) ? cur[0] : 8'h00);
			acc_spi = 1'b1;
			rd(8'h5D, (p == 0) ? cur[0] : 8'h00);
			rd(8'h00, (p == 1) ? 8'h81 : 8'h00);
			rd(8'h50, (p == 1) ? ilimv : 8'h00);
			host.fin();
			acc_spi = 1'b0;
			rd(8'h5D, cur[0]);
		end
		chk(13'(write_repeat), 13'h0);
		for (int v = 0; v < 2; v++)
			for (int b = 0; b < 2; b++)
				for (int c = 0; c < 4; c++)
				begin
					seed = lfsr(seed);
					pol = seed[0];
					if (c == 0)
						pin = 2;
					else
						pin = (v == 1) ? ((c == 3) ? 4 : c) : ((c == 3) ? 3 : c - 1);
					input_polarity = {5{pol}};
					control_in = {5{~pol}};
					settle();
					wr(8'h5D + 8'(b), 8'(c) << ((v == 1) ? 5 : 1));
					control_in[pin] = pol;
					settle();
					chk(13'(outs[v * 4 + b]), 13'(c != 0));
					control_in[pin] = ~pol;
					settle();
					chk(13'(outs[v * 4 + b]), 13'h0);
				end
		test_done();
	end
endmodule
`default_nettype wire
